// file: control_store_load_dispatch.sv
// Overview of operation
// - pack four 16-bit words into 64 bits
// - advance store address after each microinstruction
// - paging jump sets paging then dispatches
// - virtual jump sets paging and restricted
// - restricted jump sets restricted then dispatches
// - leave-paging jump clears paging then dispatches
// - jumps are two words, opcode first
// - second word points at entry address
// - dispatch takes about 2.5 microseconds
// - jumps trap when restricted mode active
// - writable store holds 256 RAM words
// - trap saves pc at vector, clears restricted
`timescale 1ns/1ps
`default_nettype none
module control_store_load_dispatch
    import cstore_pkg::*;
#(
    parameter int RAM_DEPTH = RAM_WORDS
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  addrWrite,
    input  wire logic                  dataWrite,
    input  wire logic [15:0]           ioData,
    input  wire logic                  jumpValid,
    input  wire jump_req_s             jumpReq,
    input  wire logic [15:0]           jumpPc,
    input  wire logic                  memAck,
    input  wire logic [15:0]           memRdata,
    output logic                       memValid,
    output mem_req_s                   memReq,
    output logic                       busy,
    output logic                       pagingMode,
    output logic                       restrictedMode,
    output logic                       dispatchValid,
    output logic [11:0]                dispatchAddr,
    output logic                       trapPulse,
    output logic [11:0]                csAddr,
    output logic [63:0]                microWord
);

    // ****************************************
    // loading path
    // ****************************************
    logic [63:0] ram [RAM_DEPTH];
    logic [11:0] addr_reg, addr_next;
    logic [1:0]  phase_reg, phase_next;
    logic [47:0] pack_reg, pack_next;
    logic        wr_reg, wr_next;
    logic [63:0] word_reg, word_next;
    logic [11:0] wa_reg, wa_next;

    always_comb
    begin
        addr_next  = addr_reg;
        phase_next = phase_reg;
        pack_next  = pack_reg;
        wr_next    = 1'b0;
        word_next  = word_reg;
        wa_next    = wa_reg;
        if (addrWrite)
        begin
            addr_next  = ioData[11:0];
            phase_next = PHASE_RESET;
        end
        // each data output is one word
        else if (dataWrite)
        begin
            if (phase_reg == 2'(WORDS_PER_MICRO - 1))
            begin
                word_next  = {pack_reg, ioData};
                wa_next    = addr_reg;
                wr_next    = 1'b1;
                phase_next = PHASE_RESET;
                addr_next  = addr_reg + 12'h001;
            end
            else
            begin
                pack_next  = {pack_reg[31:0], ioData};
                phase_next = phase_reg + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg  <= CS_ADDR_RESET;
            phase_reg <= PHASE_RESET;
            pack_reg  <= 48'h0;
            wr_reg    <= 1'b0;
            word_reg  <= 64'h0;
            wa_reg    <= 12'h000;
        end
        else
        begin
            addr_reg  <= addr_next;
            phase_reg <= phase_next;
            pack_reg  <= pack_next;
            wr_reg    <= wr_next;
            word_reg  <= word_next;
            wa_reg    <= wa_next;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (wr_reg && (wa_reg < 12'(PROM_WORDS + RAM_DEPTH)) && (wa_reg >= 12'(PROM_WORDS)))
        begin
            ram[8'(wa_reg - 12'(PROM_WORDS))] <= word_reg;
        end
    end

    // ****************************************
    // jump dispatch
    // ****************************************
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_WAIT  = 3'b010,
        ST_GO    = 3'b011,
        ST_TRAP  = 3'b100
    } state_e;

    state_e      st_reg, st_next;
    logic        pg_reg, pg_next, rx_reg, rx_next;
    jump_kind_e  kind_reg, kind_next;
    logic [15:0] ptr_reg, ptr_next, pc_reg, pc_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [11:0] ent_reg, ent_next;
    logic        mv_reg, mv_next, dv_reg, dv_next, tp_reg, tp_next;
    logic        bsy_reg, bsy_next;
    mem_req_s    mr_reg, mr_next;

    always_comb
    begin
        st_next   = st_reg;
        pg_next   = pg_reg;
        rx_next   = rx_reg;
        kind_next = kind_reg;
        ptr_next  = ptr_reg;
        pc_next   = pc_reg;
        cnt_next  = (cnt_reg != 16'h0) ? cnt_reg - 16'h1 : cnt_reg;
        ent_next  = ent_reg;
        mv_next   = mv_reg;
        mr_next   = mr_reg;
        dv_next   = 1'b0;
        tp_next   = 1'b0;
        case (st_reg)
            ST_IDLE:
            begin
                if (jumpValid)
                begin
                    kind_next = jumpReq.kind;
                    ptr_next  = jumpReq.pointer;
                    pc_next   = jumpPc;
                    cnt_next  = XFER_CYCLES_W - 16'h1;
                    st_next   = rx_reg ? ST_TRAP : ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                mv_next = 1'b1;
                mr_next = '{addr: ptr_reg, write: 1'b0, wdata: 16'h0};
                st_next = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (memAck)
                begin
                    mv_next  = 1'b0;
                    ent_next = memRdata[11:0];
                    st_next  = ST_GO;
                end
            end
            ST_GO:
            begin
                if (cnt_reg == 16'h0)
                begin
                    case (kind_reg)
                        enter_paging_jump_ext:     pg_next = 1'b1;
                        enter_virtual_jump_ext:
                        begin
                            pg_next = 1'b1;
                            rx_next = 1'b1;
                        end
                        enter_restricted_jump_ext: rx_next = 1'b1;
                        default:                   pg_next = 1'b0;
                    endcase
                    dv_next = 1'b1;
                    st_next = ST_IDLE;
                end
            end
            ST_TRAP:
            begin
                // store pc at vector, leave restricted
                if (!mv_reg)
                begin
                    mv_next = 1'b1;
                    mr_next = '{addr: TRAP_VECTOR, write: 1'b1, wdata: pc_reg};
                end
                else if (memAck)
                begin
                    mv_next = 1'b0;
                    rx_next = 1'b0;
                    tp_next = 1'b1;
                    st_next = ST_IDLE;
                end
            end
            default: st_next = ST_IDLE;
        endcase
        bsy_next  = (st_next != ST_IDLE);
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg   <= ST_IDLE;
            pg_reg   <= 1'b0;
            rx_reg   <= 1'b0;
            kind_reg <= enter_paging_jump_ext;
            ptr_reg  <= 16'h0;
            pc_reg   <= 16'h0;
            cnt_reg  <= 16'h0;
            ent_reg  <= 12'h000;
            mv_reg   <= 1'b0;
            mr_reg   <= '0;
            dv_reg   <= 1'b0;
            tp_reg   <= 1'b0;
            bsy_reg  <= 1'b0;
        end
        else
        begin
            st_reg   <= st_next;
            pg_reg   <= pg_next;
            rx_reg   <= rx_next;
            kind_reg <= kind_next;
            ptr_reg  <= ptr_next;
            pc_reg   <= pc_next;
            cnt_reg  <= cnt_next;
            ent_reg  <= ent_next;
            mv_reg   <= mv_next;
            mr_reg   <= mr_next;
            dv_reg   <= dv_next;
            tp_reg   <= tp_next;
            bsy_reg  <= bsy_next;
        end
    end

    always_comb
    begin
        memValid       = mv_reg;
        memReq         = mr_reg;
        busy           = bsy_reg;
        pagingMode     = pg_reg;
        restrictedMode = rx_reg;
        dispatchValid  = dv_reg;
        dispatchAddr   = ent_reg;
        trapPulse      = tp_reg;
        csAddr         = addr_reg;
        microWord      = word_reg;
    end

    // ****************************************
    // checks
    // ****************************************
    property p_pack;
        @(posedge clk_sys) disable iff (!rst_n)
        (dataWrite && !addrWrite && phase_reg == 2'h3) |=> wr_reg && word_reg[15:0] == $past(ioData);
    endproperty
    a_pack: assert property (p_pack) else $error("packing failed");

    property p_step;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_reg |-> addr_reg == wa_reg + 12'h001;
    endproperty
    a_step: assert property (p_step) else $error("address not stepped");

    property p_phase;
        @(posedge clk_sys) disable iff (!rst_n)
        addrWrite |=> phase_reg == 2'h0 && addr_reg == $past(ioData[11:0]);
    endproperty
    a_phase: assert property (p_phase) else $error("phase not reset");

    property p_trap;
        @(posedge clk_sys) disable iff (!rst_n)
        (st_reg == ST_IDLE && jumpValid && rx_reg) |=> st_reg == ST_TRAP;
    endproperty
    a_trap: assert property (p_trap) else $error("no trap");

    property p_rxclr;
        @(posedge clk_sys) disable iff (!rst_n)
        trapPulse |-> !restrictedMode && $past(memReq.addr) == TRAP_VECTOR;
    endproperty
    a_rxclr: assert property (p_rxclr) else $error("trap effects wrong");

    property p_virt;
        @(posedge clk_sys) disable iff (!rst_n)
        (dispatchValid && kind_reg == enter_virtual_jump_ext) |-> pagingMode && restrictedMode;
    endproperty
    a_virt: assert property (p_virt) else $error("virtual modes wrong");

    property p_page;
        @(posedge clk_sys) disable iff (!rst_n)
        (dispatchValid && kind_reg == enter_paging_jump_ext) |-> pagingMode;
    endproperty
    a_page: assert property (p_page) else $error("paging not set");

    property p_leave;
        @(posedge clk_sys) disable iff (!rst_n)
        (dispatchValid && kind_reg == leave_paging_jump_ext) |-> !pagingMode;
    endproperty
    a_leave: assert property (p_leave) else $error("paging not cleared");

    property p_time;
        @(posedge clk_sys) disable iff (!rst_n)
        (st_reg == ST_IDLE && jumpValid && !rx_reg) |-> ##[1:8] st_reg == ST_WAIT ##0 !dispatchValid;
    endproperty
    a_time: assert property (p_time) else $error("dispatch too early");

    property p_restr;
        @(posedge clk_sys) disable iff (!rst_n)
        (dispatchValid && kind_reg == enter_restricted_jump_ext) |-> restrictedMode;
    endproperty
    a_restr: assert property (p_restr) else $error("restricted not set");

    property p_spent;
        @(posedge clk_sys) disable iff (!rst_n)
        dispatchValid |-> $past(cnt_reg) == 16'h0;
    endproperty
    a_spent: assert property (p_spent) else $error("transfer time not spent");

endmodule : control_store_load_dispatch
`default_nettype wire

// file: control_store_load_dispatch_tb.sv
`timescale 1ns/1ps
`default_nettype none
module control_store_load_dispatch_tb;
    import cstore_pkg::*;
    // ****************************************
    // signals and instances
    // ****************************************
    logic clk_sys = 0, rst_n = 0, addrWrite = 0, dataWrite = 0, jumpValid = 0, slowMode = 0;
    logic [15:0] ioData = 0, jumpPc = 0, memRdata, lastWrAddr, lastWrData;
    jump_req_s jumpReq = '0;
    mem_req_s memReq;
    logic memAck, memValid, busy, pagingMode, restrictedMode, dispatchValid, trapPulse;
    logic [11:0] dispatchAddr, csAddr;
    logic [63:0] microWord;
    logic expP = 0, expR = 0;
    int err_total = 0, n_checks = 0;
    always #4 clk_sys = ~clk_sys;
    control_store_load_dispatch uut (.clk_sys(clk_sys), .rst_n(rst_n), .addrWrite(addrWrite),
        .dataWrite(dataWrite), .ioData(ioData), .jumpValid(jumpValid), .jumpReq(jumpReq),
        .jumpPc(jumpPc), .memAck(memAck), .memRdata(memRdata), .memValid(memValid), .memReq(memReq),
        .busy(busy), .pagingMode(pagingMode), .restrictedMode(restrictedMode),
        .dispatchValid(dispatchValid), .dispatchAddr(dispatchAddr), .trapPulse(trapPulse),
        .csAddr(csAddr), .microWord(microWord));
    cstore_mem_model mem (.clk_sys(clk_sys), .rst_n(rst_n), .slowMode(slowMode), .memValid(memValid),
        .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .lastWrAddr(lastWrAddr),
        .lastWrData(lastWrData));
    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (exp !== got)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk
    task send_addr(input logic [11:0] a);
        @(posedge clk_sys) #1 addrWrite = 1;
        ioData = {4'h0, a};
        @(posedge clk_sys) #1 addrWrite = 0;
        chk("csAddr", a, csAddr);
    endtask : send_addr
    task send_words(input logic [15:0] first, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_sys) #1 dataWrite = 1;
            ioData = first + 16'(i);
        end
        @(posedge clk_sys) #1 dataWrite = 0;
    endtask : send_words
    task stop_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    // ****************************************
    // scenarios
    // ****************************************
    task test_load;
        send_addr(12'h200);
        send_words(16'h1110, 4);
        chk("microWord", 64'h1110_1111_1112_1113, microWord);
        chk("csAddr", 12'h201, csAddr);
        send_words(16'hBEE0, 4);
        chk("microWord", 64'hBEE0_BEE1_BEE2_BEE3, microWord);
        chk("csAddr", 12'h202, csAddr);
        chk("ram0", 64'h1110_1111_1112_1113, uut.ram[0]);
    endtask : test_load
    task test_restart;
        send_addr(12'h2F0);
        send_words(16'hC0C0, 2);
        send_addr(12'h2FF);
        send_words(16'hD000, 4);
        chk("microWord", 64'hD000_D001_D002_D003, microWord);
        chk("csAddr", 12'h300, csAddr);
        @(posedge clk_sys) #1;
        chk("ram255", 64'hD000_D001_D002_D003, uut.ram[255]);
    endtask : test_restart
    task test_reset;
        @(posedge clk_sys) #1 rst_n = 0;
        @(posedge clk_sys) #1;
        chk("midReset", 0, {busy, pagingMode, restrictedMode, dispatchValid, csAddr});
        rst_n = 1;
        @(posedge clk_sys) #1;
        chk("afterReset", 0, {busy, pagingMode, restrictedMode, trapPulse, csAddr});
        send_addr(12'h210);
    endtask : test_reset
    task do_jump(input jump_kind_e k, input logic [15:0] ptr, input logic [15:0] pc, input logic trap);
        int n;
        @(posedge clk_sys) #1 jumpValid = 1;
        jumpReq = '{k, ptr};
        jumpPc = pc;
        n = 0;
        while (dispatchValid !== 1'b1 && trapPulse !== 1'b1 && n < 2000)
        begin
            @(posedge clk_sys) #1 jumpValid = (n == 5);
            if (n == 0)
                chk("busyHigh", 1, busy);
            n++;
        end
        jumpValid = 0;
        chk("busyLow", 0, busy);
        if (trap)
        begin
            expR = 0;
            chk("trapPulse", 1, trapPulse);
            chk("dispatchValid", 0, dispatchValid);
            chk("trapAddr", TRAP_VECTOR, lastWrAddr);
            chk("trapPc", pc, lastWrData);
        end
        else
        begin
            case (k)
                enter_paging_jump_ext:     expP = 1;
                enter_virtual_jump_ext:    {expP, expR} = 2'h3;
                enter_restricted_jump_ext: expR = 1;
                default:                   expP = 0;
            endcase
            chk("dispatchValid", 1, dispatchValid);
            chk("dispatchAddr", 12'h200 + {4'h0, ptr[7:0]}, dispatchAddr);
            chk("xferShort", 1, n >= XFER_CYCLES);
            chk("xferLong", 1, n <= XFER_CYCLES + 40);
        end
        chk("pagingMode", expP, pagingMode);
        chk("restrictedMode", expR, restrictedMode);
        @(posedge clk_sys) #1;
        chk("onePulse", 0, dispatchValid | trapPulse);
    endtask : do_jump
    task test_jumps;
        do_jump(enter_paging_jump_ext, 16'h0411, 16'h1000, 0);
        do_jump(leave_paging_jump_ext, 16'h0422, 16'h1002, 0);
        slowMode = 1;
        do_jump(enter_restricted_jump_ext, 16'h0433, 16'h1004, 0);
        do_jump(enter_paging_jump_ext, 16'h0444, 16'h1006, 1);
        slowMode = 0;
        do_jump(enter_virtual_jump_ext, 16'h0455, 16'h1008, 0);
        do_jump(leave_paging_jump_ext, 16'h0466, 16'h100A, 1);
    endtask : test_jumps
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (12) @(posedge clk_sys);
        #1 rst_n = 1;
        chk("resetState", 0, {busy, pagingMode, restrictedMode, csAddr});
        test_load;
        test_restart;
        test_jumps;
        test_reset;
        stop_test;
    end
    initial
    begin
        #(8 * 20000);
        err_total++;
        stop_test;
    end
endmodule : control_store_load_dispatch_tb
`default_nettype wire

// file: cstore_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cstore_mem_model
    import cstore_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     rst_n,
    input  wire logic     slowMode,
    input  wire logic     memValid,
    input  wire mem_req_s memReq,
    output logic          memAck,
    output logic [15:0]   memRdata,
    output logic [15:0]   lastWrAddr,
    output logic [15:0]   lastWrData
);
    // ****************************************
    // main memory answering fetches and saves
    // ****************************************
    int waitCnt;
    initial
    begin
        memAck     = 1'b0;
        memRdata   = 16'hA5A5;
        lastWrAddr = 16'h0000;
        lastWrData = 16'h0000;
        waitCnt    = 0;
    end
    always @(posedge clk_sys)
    begin
        #1;
        if (memAck || !rst_n || !memValid)
        begin
            memAck   = 1'b0;
            memRdata = ~memRdata;
        end
        else if (waitCnt < (slowMode ? 20 : 0))
            waitCnt++;
        else
        begin
            memAck  = 1'b1;
            waitCnt = 0;
            if (memReq.write)
            begin
                lastWrAddr = memReq.addr;
                lastWrData = memReq.wdata;
            end
            else
                memRdata = 16'h0200 + {8'h00, memReq.addr[7:0]};
        end
    end
endmodule : cstore_mem_model
`default_nettype wire

// file: cstore_pkg.sv
package cstore_pkg;

    // ****************************************
    // sizes and constants
    // ****************************************
    localparam int          HOST_WORD_W      = 16;
    localparam int          MICRO_W          = 64;
    localparam int          WORDS_PER_MICRO  = 4;
    localparam int          CS_ADDR_W        = 12;
    localparam int          PROM_WORDS       = 512;
    localparam int          RAM_WORDS        = 256;
    localparam logic [15:0] TRAP_VECTOR      = 16'h0032;
    localparam logic [11:0] CS_ADDR_RESET    = 12'h000;
    localparam logic [1:0]  PHASE_RESET      = 2'h0;
    localparam int          CLK_MHZ          = 125;
    localparam int          XFER_NS          = 2500;
    localparam int          XFER_CYCLES      = (XFER_NS * CLK_MHZ) / 1000;
    localparam logic [15:0] XFER_CYCLES_W    = 16'(XFER_CYCLES);

    // ****************************************
    // jump kinds
    // ****************************************
    typedef enum logic [1:0]
    {
        enter_paging_jump_ext     = 2'h0,
        enter_virtual_jump_ext    = 2'h1,
        enter_restricted_jump_ext = 2'h2,
        leave_paging_jump_ext     = 2'h3
    } jump_kind_e;

    typedef struct packed
    {
        jump_kind_e  kind;
        logic [15:0] pointer;
    } jump_req_s;

    typedef struct packed
    {
        logic [15:0] addr;
        logic        write;
        logic [15:0] wdata;
    } mem_req_s;

endpackage : cstore_pkg
